// ===== design/cgs_clock_gen.sv
// clock generator: oscillator control, stabilization counting, stop mode,
// glitch-free main clock select and cpu prescaler, all as clock ticks
// assumes one 100 MHz clock; crystal or external clock arrives on a pin
//
// What this block does
// - internal 4 MHz oscillator runs after reset
// - low-speed clock only feeds watchdog, timer H1
// - option strap decides if low-speed is stoppable
// - low-speed 240 kHz starts at reset, drives watchdog
// - prescaler divides main clock feeding the cpu
// - cpu always starts on internal high-speed clock
// - cpu released only after supply settle time
// - settle time also covers oscillator accuracy
// - clock pins reset to general port mode
// - ext 0, pin select 1 gives crystal mode
// - clearing oscillator stop bit starts the crystal
// - external clock input needs no settling wait
// - stop halts high-speed clocks; unused ones stoppable
// - stop exit waits selected time on crystal clock
// - select field resets 101b, codes 1..5 valid
// - status bits set in order, kept until stop bit or stop entry clears them
`timescale 1ns/1ps
module cgs_clock_gen #(
  parameter int unsigned VSTAB_CYCLES = cgs_pkg::VSTAB_CYC
) (
  // clock and reset
  input  wire  logic       clock,
  input  wire  logic       resetn,
  // register port
  input  wire  logic [3:0] addr,
  input  wire  logic [7:0] wdata,
  input  wire  logic       wstrobe,
  input  wire  logic       rstrobe,
  output logic       [7:0] rdata,
  // option straps and cpu events
  input  wire  logic       opt_ls_stoppable,
  input  wire  logic       opt_wdt_enable,
  input  wire  logic       stop_instr,
  input  wire  logic       stop_wakeup,
  // high-speed clock pin, crystal or external input
  input  wire  logic       hs_sys_clk,
  // oscillator and pin control
  output logic             int_hs_osc_run,
  output logic             int_ls_osc_run,
  output logic             crystal_osc_enable,
  output logic             ext_clk_input_enable,
  output logic             pins_port_mode,
  // clock ticks and cpu state
  output logic             int_ls_osc_clk,
  output logic             wdt_clk_tick,
  output logic             main_clk_tick,
  output logic             cpu_clk_tick,
  output logic             cpu_run,
  output logic             stop_mode
);
  import cgs_pkg::*;

  logic [1:0]            rst_sync;
  logic                  rst_n;
  logic [2:0]            pin_sync;
  logic                  pin_level;
  logic                  pin_prev;
  logic                  hs_sys_tick;
  logic [7:0]            hs_div_cnt;
  logic                  int_hs_osc_clk;
  logic [9:0]            ls_div_cnt;
  logic [31:0]           vstab_cnt;
  cgs_state_e            state;
  logic                  ext_clock_select;
  logic                  osc_pin_select;
  logic                  hs_sys_osc_stop;
  logic                  ihs_stop;
  logic                  ils_stop;
  logic                  xsel;
  logic                  mcm0;
  logic                  mcs;
  logic                  sel_pending;
  logic [2:0]            stab_time_select;
  logic [2:0]            cpu_div;
  logic [4:0]            cpu_div_cnt;
  logic [STAB_CNT_W-1:0] stab_cnt;
  logic [4:0]            stab_counter_status;
  cgs_pin_mode_e         pin_mode;
  logic                  hs_sys_running;
  logic                  ihs_running;
  logic                  next_main_tick;
  // wait length in crystal periods for a select code
  function automatic logic [STAB_CNT_W-1:0] stab_limit(input logic [2:0] code);
    case (code)
      3'h1:    stab_limit = 17'h00800;
      3'h2:    stab_limit = 17'h02000;
      3'h3:    stab_limit = 17'h04000;
      3'h4:    stab_limit = 17'h08000;
      default: stab_limit = 17'h10000;
    endcase
  endfunction : stab_limit
  // reset release through two flip-flops
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];
  // pin filter: a change counts once stages two and three agree
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pin_sync  <= 3'h0;
      pin_level <= 1'b0;
      pin_prev  <= 1'b0;
    end else begin
      pin_sync <= {pin_sync[1:0], hs_sys_clk};
      if (pin_sync[1] == pin_sync[2]) begin
        pin_level <= pin_sync[2];
      end
      pin_prev <= pin_level;
    end
  end
  // pin mode decode, port mode until software picks a source
  assign pin_mode = !osc_pin_select  ? CGS_PIN_PORT :
                    ext_clock_select ? CGS_PIN_EXT  : CGS_PIN_XTAL;
  // stop mode halts both high-speed sources
  assign hs_sys_running = (pin_mode != CGS_PIN_PORT) && !hs_sys_osc_stop &&
                          (state != CGS_STOP);
  assign ihs_running    = !ihs_stop && (state != CGS_STOP);
  assign hs_sys_tick    = hs_sys_running && pin_level && !pin_prev;
  // internal high-speed oscillator, free from software after reset
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hs_div_cnt     <= 8'h0;
      int_hs_osc_clk <= 1'b0;
    end else begin
      int_hs_osc_clk <= 1'b0;
      if (ihs_running) begin
        if (hs_div_cnt == 8'(HS_DIV - 1)) begin
          hs_div_cnt     <= 8'h0;
          int_hs_osc_clk <= 1'b1;
        end else begin
          hs_div_cnt <= hs_div_cnt + 8'h1;
        end
      end
    end
  end
  // low-speed oscillator, never routed to the cpu
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ls_div_cnt     <= 10'h0;
      int_ls_osc_clk <= 1'b0;
      wdt_clk_tick   <= 1'b0;
      int_ls_osc_run <= 1'b0;
    end else begin
      int_ls_osc_clk <= 1'b0;
      wdt_clk_tick   <= 1'b0;
      int_ls_osc_run <= !(opt_ls_stoppable && ils_stop);
      if (!(opt_ls_stoppable && ils_stop)) begin
        if (ls_div_cnt == 10'(LS_DIV - 1)) begin
          ls_div_cnt     <= 10'h0;
          int_ls_osc_clk <= 1'b1;
          wdt_clk_tick   <= opt_wdt_enable;
        end else begin
          ls_div_cnt <= ls_div_cnt + 10'h1;
        end
      end
    end
  end
  // power-up wait, stop and wakeup sequencing
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state     <= CGS_PWR_WAIT;
      vstab_cnt <= 32'h0;
    end else begin
      case (state)
        CGS_PWR_WAIT: begin
          // one span for regulator and internal oscillator accuracy
          if (vstab_cnt == 32'(VSTAB_CYCLES - 1)) begin
            state <= CGS_RUN;
          end else begin
            vstab_cnt <= vstab_cnt + 32'h1;
          end
        end
        CGS_RUN: begin
          if (stop_instr) begin
            state <= CGS_STOP;
          end
        end
        CGS_STOP: begin
          if (stop_wakeup) begin
            // external clock or internal cpu clock resume at once
            state <= (mcs && pin_mode == CGS_PIN_XTAL) ? CGS_WAKE : CGS_RUN;
          end
        end
        CGS_WAKE: begin
          if (stab_cnt >= stab_limit(stab_time_select)) begin
            state <= CGS_RUN;
          end
        end
        default: state <= CGS_PWR_WAIT;
      endcase
    end
  end
  // register writes; a running cpu source cannot be stopped
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ext_clock_select <= 1'b0;
      osc_pin_select   <= 1'b0;
      hs_sys_osc_stop  <= RST_MAIN_OSC[BIT_HS_STOP];
      ihs_stop         <= 1'b0;
      ils_stop         <= 1'b0;
      xsel             <= 1'b0;
      mcm0             <= 1'b0;
      stab_time_select <= RST_STAB_SEL;
      cpu_div          <= RST_CPU_DIV;
    end else if (wstrobe) begin
      case (addr)
        ADDR_PIN_CTL: begin
          // pin mode is trusted to stay put while the source runs
          ext_clock_select <= wdata[BIT_EXT_CLK];
          osc_pin_select   <= wdata[BIT_OSC_SEL];
        end
        ADDR_MAIN_OSC: begin
          if (!(mcs && wdata[BIT_HS_STOP])) begin
            hs_sys_osc_stop <= wdata[BIT_HS_STOP];
          end
        end
        ADDR_INT_OSC: begin
          if (!(!mcs && wdata[BIT_IHS_STOP])) begin
            ihs_stop <= wdata[BIT_IHS_STOP];
          end
          ils_stop <= wdata[BIT_ILS_STOP] && opt_ls_stoppable;
        end
        ADDR_CLK_SEL: begin
          // only a single source choice: crystal/external or internal
          xsel <= wdata[BIT_XSEL];
          mcm0 <= wdata[BIT_MCM0];
        end
        ADDR_STAB_SEL: begin
          if (wdata[2:0] >= STAB_SEL_MIN && wdata[2:0] <= STAB_SEL_MAX) begin
            stab_time_select <= wdata[2:0];
          end
        end
        ADDR_CPU_DIV: begin
          if (wdata[2:0] <= CPU_DIV_MAX) begin
            cpu_div <= wdata[2:0];
          end
        end
        default: ;
      endcase
    end
  end
  // stabilization counter: cleared by stop bit, stop entry and reset
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      stab_cnt            <= '0;
      stab_counter_status <= 5'h0;
    end else if (hs_sys_osc_stop || state == CGS_STOP) begin
      stab_cnt            <= '0;
      stab_counter_status <= 5'h0;
    end else begin
      if (hs_sys_tick && stab_cnt < stab_limit(STAB_SEL_MAX)) begin
        stab_cnt <= stab_cnt + 17'h1;
      end
      // during the stop exit wait only bits up to the selected time may set
      for (int i = 0; i < 5; i++) begin
        if (stab_cnt >= stab_limit(3'(i + 1)) &&
            (state != CGS_WAKE || 3'(i + 1) <= stab_time_select)) begin
          stab_counter_status[4 - i] <= 1'b1;
        end
      end
    end
  end
  // main clock select: change only on a tick of the new source,
  // and only once the old one ticked, so no shortened period appears
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mcs         <= 1'b0;
      sel_pending <= 1'b0;
    end else begin
      if ((xsel && mcm0) != mcs) begin
        if (mcs ? hs_sys_tick : int_hs_osc_clk) begin
          sel_pending <= 1'b1;
        end
        if (sel_pending && (mcs ? int_hs_osc_clk : hs_sys_tick)) begin
          mcs         <= !mcs;
          sel_pending <= 1'b0;
        end
      end else begin
        sel_pending <= 1'b0;
      end
    end
  end
  // selected main tick, muted while a switch is pending; no low-speed path
  assign next_main_tick = !sel_pending &&
                          (mcs ? hs_sys_tick : int_hs_osc_clk);
  // prescaler and cpu tick
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      main_clk_tick <= 1'b0;
      cpu_clk_tick  <= 1'b0;
      cpu_div_cnt   <= 5'h0;
    end else begin
      main_clk_tick <= next_main_tick;
      cpu_clk_tick  <= 1'b0;
      if (next_main_tick) begin
        if (cpu_div_cnt >= 5'((1 << cpu_div) - 1)) begin
          cpu_div_cnt  <= 5'h0;
          cpu_clk_tick <= (state == CGS_RUN);
        end else begin
          cpu_div_cnt <= cpu_div_cnt + 5'h1;
        end
      end
    end
  end
  // status outputs
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      int_hs_osc_run       <= 1'b0;
      crystal_osc_enable   <= 1'b0;
      ext_clk_input_enable <= 1'b0;
      pins_port_mode       <= 1'b1;
      cpu_run              <= 1'b0;
      stop_mode            <= 1'b0;
    end else begin
      int_hs_osc_run       <= ihs_running;
      crystal_osc_enable   <= hs_sys_running && pin_mode == CGS_PIN_XTAL;
      ext_clk_input_enable <= hs_sys_running && pin_mode == CGS_PIN_EXT;
      pins_port_mode       <= (pin_mode == CGS_PIN_PORT);
      cpu_run              <= (state == CGS_RUN);
      stop_mode            <= (state == CGS_STOP || state == CGS_WAKE);
    end
  end
  // read data, one cycle after the strobe
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 8'h0;
    end else begin
      rdata <= 8'h0;
      if (rstrobe) begin
        case (addr)
          ADDR_PIN_CTL: begin
            rdata[BIT_EXT_CLK] <= ext_clock_select;
            rdata[BIT_OSC_SEL] <= osc_pin_select;
          end
          ADDR_MAIN_OSC: rdata[BIT_HS_STOP] <= hs_sys_osc_stop;
          ADDR_INT_OSC: begin
            rdata[BIT_IHS_STOP]  <= ihs_stop;
            rdata[BIT_ILS_STOP]  <= ils_stop;
            rdata[BIT_IHS_READY] <= ihs_running && state != CGS_PWR_WAIT;
          end
          ADDR_CLK_SEL: begin
            rdata[BIT_XSEL] <= xsel;
            rdata[BIT_MCS]  <= mcs;
            rdata[BIT_MCM0] <= mcm0;
          end
          ADDR_STAB_ST:  rdata <= {3'h0, stab_counter_status};
          ADDR_STAB_SEL: rdata <= {5'h0, stab_time_select};
          ADDR_CPU_DIV:  rdata <= {5'h0, cpu_div};
          default:       rdata <= 8'h0;
        endcase
      end
    end
  end
endmodule : cgs_clock_gen

// ===== design/cgs_pkg.sv
// constants shared by the clock generator and its bench
// assumes a single 100 MHz system clock drives all logic
package cgs_pkg;
  localparam int unsigned CLK_MHZ       = 100;
  // oscillator rates, as nominal figures
  localparam int unsigned HS_OSC_KHZ    = 4000;
  localparam int unsigned LS_OSC_KHZ    = 240;
  localparam int unsigned HS_DIV        = CLK_MHZ * 1000 / HS_OSC_KHZ;
  localparam int unsigned LS_DIV        = CLK_MHZ * 1000 / LS_OSC_KHZ;
  // supply plus regulator settle time, covers oscillator accuracy settling
  localparam int unsigned VSTAB_US      = 100;
  localparam int unsigned VSTAB_CYC     = VSTAB_US * CLK_MHZ;
  // register indices
  localparam logic [3:0]  ADDR_PIN_CTL  = 4'h0;
  localparam logic [3:0]  ADDR_MAIN_OSC = 4'h1;
  localparam logic [3:0]  ADDR_INT_OSC  = 4'h2;
  localparam logic [3:0]  ADDR_CLK_SEL  = 4'h3;
  localparam logic [3:0]  ADDR_STAB_ST  = 4'h4;
  localparam logic [3:0]  ADDR_STAB_SEL = 4'h5;
  localparam logic [3:0]  ADDR_CPU_DIV  = 4'h6;
  // field positions
  localparam int unsigned BIT_OSC_SEL   = 4;
  localparam int unsigned BIT_EXT_CLK   = 5;
  localparam int unsigned BIT_HS_STOP   = 7;
  localparam int unsigned BIT_IHS_STOP  = 0;
  localparam int unsigned BIT_ILS_STOP  = 1;
  localparam int unsigned BIT_IHS_READY = 7;
  localparam int unsigned BIT_MCM0      = 0;
  localparam int unsigned BIT_MCS       = 1;
  localparam int unsigned BIT_XSEL      = 2;
  // reset values
  localparam logic [7:0]  RST_MAIN_OSC  = 8'h80;
  localparam logic [2:0]  RST_STAB_SEL  = 3'h5;
  localparam logic [2:0]  RST_CPU_DIV   = 3'h1;
  localparam logic [2:0]  CPU_DIV_MAX   = 3'h4;
  localparam logic [2:0]  STAB_SEL_MIN  = 3'h1;
  localparam logic [2:0]  STAB_SEL_MAX  = 3'h5;
  localparam int unsigned STAB_CNT_W    = 17;
  typedef enum logic [1:0] {
    CGS_PIN_PORT,
    CGS_PIN_XTAL,
    CGS_PIN_EXT
  } cgs_pin_mode_e;
  typedef enum logic [1:0] {
    CGS_PWR_WAIT,
    CGS_RUN,
    CGS_STOP,
    CGS_WAKE
  } cgs_state_e;
endpackage : cgs_pkg

// ===== testbench/cgs_clock_gen_properties.sv
// port checker for the clock generator
// assumes resetn is the raw async reset seen at the top ports
`timescale 1ns/1ps
module cgs_clock_gen_properties #(
  parameter int unsigned VSTAB_CYCLES = 20
) (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // straps and cpu events
  input wire logic opt_ls_stoppable,
  input wire logic opt_wdt_enable,
  input wire logic stop_instr,
  // watched outputs
  input wire logic int_ls_osc_run,
  input wire logic crystal_osc_enable,
  input wire logic ext_clk_input_enable,
  input wire logic pins_port_mode,
  input wire logic int_ls_osc_clk,
  input wire logic wdt_clk_tick,
  input wire logic main_clk_tick,
  input wire logic cpu_clk_tick,
  input wire logic cpu_run,
  input wire logic stop_mode
);
  // cycles since reset release, saturating so it never wraps in long runs
  logic [31:0] up_cnt;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) up_cnt <= '0;
    else if (up_cnt < 32'hffff) up_cnt <= up_cnt + 32'h1;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  a_cpu_after_settle: assert property (cpu_run |-> up_cnt >= VSTAB_CYCLES)
    else $error("cpu released early");
  a_ls_not_stoppable: assert property (up_cnt > 6 && !opt_ls_stoppable |-> int_ls_osc_run)
    else $error("low-speed osc stopped");
  a_ls_tick_space: assert property (int_ls_osc_clk |=> !int_ls_osc_clk [*8])
    else $error("low-speed tick too fast");
  a_wdt_gated: assert property (wdt_clk_tick |-> opt_wdt_enable)
    else $error("watchdog tick while disabled");
  a_wdt_follows_ls: assert property ($rose(int_ls_osc_clk) && opt_wdt_enable |-> ##[0:1] wdt_clk_tick)
    else $error("watchdog tick missing");
  a_main_no_runt: assert property (main_clk_tick |=> !main_clk_tick [*3])
    else $error("runt main tick");
  a_cpu_tick_run: assert property (cpu_clk_tick |-> cpu_run)
    else $error("cpu tick outside run");
  a_stop_no_cpu: assert property (stop_mode |-> !cpu_run && !cpu_clk_tick)
    else $error("cpu active in stop");
  a_stop_entry: assert property (cpu_run && stop_instr |-> ##[1:2] stop_mode)
    else $error("stop not entered");
  a_xtal_pins: assert property (crystal_osc_enable |-> !pins_port_mode && !ext_clk_input_enable)
    else $error("crystal mode with port pins");
  c_cpu_start: cover property ($rose(cpu_run));
  c_stop: cover property ($rose(stop_mode));
  c_xtal: cover property ($rose(crystal_osc_enable));
  c_ext: cover property ($rose(ext_clk_input_enable));
endmodule : cgs_clock_gen_properties

bind cgs_clock_gen cgs_clock_gen_properties #(.VSTAB_CYCLES(VSTAB_CYCLES)) cgs_clock_gen_properties_i (
  .clock, .resetn, .opt_ls_stoppable, .opt_wdt_enable, .stop_instr, .int_ls_osc_run,
  .crystal_osc_enable, .ext_clk_input_enable, .pins_port_mode, .int_ls_osc_clk,
  .wdt_clk_tick, .main_clk_tick, .cpu_clk_tick, .cpu_run, .stop_mode
);

// ===== testbench/cgs_clock_gen_test.sv
// self-checking bench for the clock generator
// assumes the crystal model drives the high-speed clock pin
`timescale 1ns/1ps
module cgs_clock_gen_test;
  import cgs_pkg::*;
  localparam int unsigned VST  = 20;
  localparam int unsigned HALF = 3;
  logic       clock, resetn, wstrobe, rstrobe, opt_ls_stoppable, opt_wdt_enable;
  logic       stop_instr, stop_wakeup, hs_sys_clk, int_hs_osc_run, int_ls_osc_run;
  logic       crystal_osc_enable, ext_clk_input_enable, pins_port_mode, int_ls_osc_clk;
  logic       wdt_clk_tick, main_clk_tick, cpu_clk_tick, cpu_run, stop_mode;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, v, sel, div;
  int         n_errors, n_checks, seed, cyc, i;
  logic [7:0] exp_rst [8];
  cgs_clock_gen #(.VSTAB_CYCLES(VST)) cgs_clock_gen_i (
    .clock, .resetn, .addr, .wdata, .wstrobe, .rstrobe, .rdata, .opt_ls_stoppable,
    .opt_wdt_enable, .stop_instr, .stop_wakeup, .hs_sys_clk, .int_hs_osc_run, .int_ls_osc_run,
    .crystal_osc_enable, .ext_clk_input_enable, .pins_port_mode, .int_ls_osc_clk,
    .wdt_clk_tick, .main_clk_tick, .cpu_clk_tick, .cpu_run, .stop_mode
  );
  cgs_xtal_model #(.HALF(HALF)) cgs_xtal_model_i (
    .clock, .crystal_osc_enable, .ext_clk_input_enable, .hs_sys_clk
  );
  initial begin
    clock = 1'b0;
    forever #5 clock = !clock;
  end
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic end_sim;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_sim
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    addr    <= a;
    wdata   <= d;
    wstrobe <= 1'b1;
    @(posedge clock);
    wstrobe <= 1'b0;
  endtask : wr
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clock);
    addr    <= a;
    rstrobe <= 1'b1;
    @(posedge clock);
    rstrobe <= 1'b0;
    #1 d = rdata;
  endtask : rd
  task automatic wait_cpu(input int lim);
    cyc = 0;
    while (cpu_run !== 1'b1 && cyc < lim) begin
      @(posedge clock);
      #1;
      cyc++;
    end
  endtask : wait_cpu
  task automatic count(input int n, input bit on_main, output int c);
    c = 0;
    repeat (n) begin
      tick(1);
      c += on_main ? int'(main_clk_tick === 1'b1) : int'(cpu_clk_tick === 1'b1);
    end
  endtask : count
  function automatic logic [7:0] keep(input logic [7:0] old, input logic [7:0] code,
                                      input logic [2:0] lo, input logic [2:0] hi);
    return (code[2:0] >= lo && code[2:0] <= hi) ? code : old;
  endfunction : keep
  task automatic rst(input logic wdt);
    resetn         <= 1'b0;
    opt_wdt_enable <= wdt;
    tick(6);
    chk("port mode in reset", {7'h0, pins_port_mode}, 8'h01);
    chk("cpu in reset", {7'h0, cpu_run}, 8'h00);
    resetn <= 1'b1;
    wait_cpu(200);
    chk("settle wait", {7'h0, cyc >= VST}, 8'h01);
    chk("hs osc boots", {7'h0, int_hs_osc_run}, 8'h01);
    chk("ls osc boots", {7'h0, int_ls_osc_run}, 8'h01);
  endtask : rst
  task automatic to_hs;
    wr(ADDR_CLK_SEL, 8'h05);
    v = 8'h00;
    for (i = 0; i < 100 && !v[1]; i++) rd(ADDR_CLK_SEL, v);
    chk("switched to hs", v, 8'h07);
  endtask : to_hs
  task automatic stop_wake(input int lim);
    @(posedge clock);
    stop_instr <= 1'b1;
    @(posedge clock);
    stop_instr <= 1'b0;
    tick(4);
    chk("stop entered", {7'h0, stop_mode}, 8'h01);
    chk("hs halted", {7'h0, int_hs_osc_run | crystal_osc_enable | ext_clk_input_enable},
        8'h00);
    tick(20);
    stop_wakeup <= 1'b1;
    @(posedge clock);
    stop_wakeup <= 1'b0;
    wait_cpu(lim);
  endtask : stop_wake
  initial begin
    #600_000;
    n_errors++;
    end_sim;
  end
  initial begin
    {resetn, wstrobe, rstrobe, stop_instr, stop_wakeup, opt_ls_stoppable} = '0;
    opt_wdt_enable = 1'b1;
    addr           = 4'h0;
    wdata          = 8'h00;
    n_errors       = 0;
    n_checks       = 0;
    seed           = 1;
    exp_rst = '{8'h00, RST_MAIN_OSC, 8'h80, 8'h00, 8'h00, {5'h0, RST_STAB_SEL},
                {5'h0, RST_CPU_DIV}, 8'h00};
    rst(1'b1);
    wr(4'h7, 8'hff);
    for (i = 0; i < 8; i++) begin
      rd(4'(i), v);
      chk("reset value", v, exp_rst[i]);
    end
    sel = exp_rst[5];
    div = exp_rst[6];
    // codes 0..7 once each, then random codes
    for (i = 0; i < 16; i++) begin
      v = (i < 8) ? 8'(i) : 8'($random(seed)) & 8'h07;
      wr(ADDR_STAB_SEL, v);
      wr(ADDR_CPU_DIV, v);
      sel = keep(sel, v, STAB_SEL_MIN, STAB_SEL_MAX);
      div = keep(div, v, 3'h0, CPU_DIV_MAX);
      rd(ADDR_STAB_SEL, v);
      chk("stab select", v, sel);
      rd(ADDR_CPU_DIV, v);
      chk("cpu divider", v, div);
    end
    for (i = 0; i < 3; i++) begin
      wr(ADDR_CPU_DIV, 8'(i));
      count(400, 1'b0, cyc);
      chk("cpu tick rate", 8'(cyc), 8'(400 / (25 << i)));
    end
    wr(ADDR_INT_OSC, 8'h02);
    tick(4);
    chk("ls osc kept", {7'h0, int_ls_osc_run}, 8'h01);
    opt_ls_stoppable <= 1'b1;
    wr(ADDR_INT_OSC, 8'h03);
    tick(4);
    chk("ls osc stopped", {7'h0, int_ls_osc_run}, 8'h00);
    chk("cpu hs osc kept", {7'h0, int_hs_osc_run}, 8'h01);
    wr(ADDR_INT_OSC, 8'h00);
    wr(ADDR_PIN_CTL, 8'h10); // pin mode set only while the crystal is stopped
    tick(3);
    chk("pins leave port", {7'h0, pins_port_mode}, 8'h00);
    wr(ADDR_MAIN_OSC, 8'h00);
    tick(3);
    chk("crystal on", {7'h0, crystal_osc_enable}, 8'h01);
    v = 8'h00;
    for (cyc = 0; cyc < 8000 && !v[4]; cyc++) begin
      rd(ADDR_STAB_ST, v);
      chk("status order", {7'h0, v inside {8'h00, 8'h10, 8'h18, 8'h1c, 8'h1e, 8'h1f}},
          8'h01);
    end
    chk("first status time", {7'h0, cyc * 2 >= 2047 * 2 * HALF}, 8'h01);
    wr(ADDR_STAB_SEL, 8'h01);
    to_hs();
    wr(ADDR_MAIN_OSC, 8'h80);
    tick(3);
    chk("crystal kept", {7'h0, crystal_osc_enable}, 8'h01);
    count(600, 1'b1, cyc);
    chk("main tick rate", 8'(cyc), 8'(600 / (2 * HALF)));
    stop_wake(20000);
    chk("stop exit wait", {7'h0, cyc >= 2047 * 2 * HALF}, 8'h01);
    chk("cpu resumes", {7'h0, cpu_run}, 8'h01);
    rd(ADDR_STAB_ST, v);
    chk("status after wake", v, 8'h10);
    wr(ADDR_INT_OSC, 8'h01);
    tick(3);
    chk("idle hs osc stops", {7'h0, int_hs_osc_run}, 8'h00);
    rst(1'b0);
    wr(ADDR_PIN_CTL, 8'h30); // pin mode set only while the input is stopped
    wr(ADDR_MAIN_OSC, 8'h00);
    tick(3);
    chk("ext input on", {6'h0, ext_clk_input_enable, crystal_osc_enable}, 8'h02);
    to_hs();
    stop_wake(6);
    chk("ext no wait", {7'h0, cpu_run}, 8'h01);
    tick(900);
    end_sim;
  end
endmodule : cgs_clock_gen_test

// ===== testbench/cgs_xtal_model.sv
// crystal or external clock source on the high-speed clock pin
// assumes the generator enable outputs say when the pin may toggle
`timescale 1ns/1ps
module cgs_xtal_model #(
  parameter int unsigned HALF = 3
) (
  input  wire logic clock,
  input  wire logic crystal_osc_enable,
  input  wire logic ext_clk_input_enable,
  output logic      hs_sys_clk
);
  // pin is unknown until the first edge; the generator sits in reset then
  int unsigned cnt = 0;
  // a halted source stands still low, no stray edges
  always @(posedge clock) begin
    if (!(crystal_osc_enable || ext_clk_input_enable)) begin
      hs_sys_clk <= 1'b0;
      cnt        <= 0;
    end else if (cnt == HALF - 1) begin // runs once enabled
      hs_sys_clk <= !hs_sys_clk;
      cnt        <= 0;
    end else cnt <= cnt + 1;
  end
endmodule : cgs_xtal_model
